// *** rtl/texu_pkg.sv ***
// Package with the register map, field layouts and carrier types of the texture unit.
package texu_pkg;

   // Word offsets on the register bus, byte address is the offset times four.
   localparam logic [5:0] TEXU_W_MODE    = 6'h00;
   localparam logic [5:0] TEXU_W_LEVEL   = 6'h01;
   localparam logic [5:0] TEXU_W_DETAIL  = 6'h02;
   localparam logic [5:0] TEXU_W_BASE0   = 6'h03;
   localparam logic [5:0] TEXU_W_TABLE0  = 6'h10;
   localparam logic [5:0] TEXU_W_TABLE1  = 6'h20;
   localparam logic [3:0] TEXU_TBL_WORDS = 4'hc;
   localparam logic [3:0] TEXU_TBL_LUMA  = 4'h4;

   // Reset value of every configuration register.
   localparam logic [31:0] TEXU_RESET_VAL = 32'h0000_0000;

   // Field positions in the texture mode register.
   localparam int TEXU_MODE_MIN_FILT = 1;
   localparam int TEXU_MODE_MAG_FILT = 2;
   localparam int TEXU_MODE_TBL_SEL  = 5;
   localparam int TEXU_MODE_FMT_LO   = 8;
   localparam int TEXU_MODE_SEQ8     = 31;

   // Palette write marker bit in table chroma writes.
   localparam int TEXU_PAL_MARK = 31;

   // Upper level-of-detail limit 8.0 in unsigned 4.2.
   localparam logic [5:0] TEXU_LOD_CEIL = 6'h20;

   // Texel format codes handled here.
   localparam logic [3:0] TEXU_FMT_ARGB8332 = 4'h8;
   localparam logic [3:0] TEXU_FMT_ALCC     = 4'h9;
   localparam logic [3:0] TEXU_FMT_RGB565   = 4'ha;
   localparam logic [3:0] TEXU_FMT_ARGB1555 = 4'hb;
   localparam logic [3:0] TEXU_FMT_ARGB4444 = 4'hc;
   localparam logic [3:0] TEXU_FMT_AI88     = 4'hd;
   localparam logic [3:0] TEXU_FMT_AP88     = 4'he;

   // Layout of the texture level control register.
   typedef struct packed {
      logic [3:0] rsvd;
      logic       direct_write;
      logic       half_swap;
      logic       byte_reverse;
      logic       multi_base;
      logic       zero_frac;
      logic [1:0] aspect;
      logic       horizontal_wider_flag;
      logic       split;
      logic       odd;
      logic [5:0] bias;
      logic [5:0] lod_max;
      logic [5:0] lod_min;
   } texu_level_t;

   // Layout of the detail texture control register.
   typedef struct packed {
      logic [9:0] rsvd;
      logic       separate;
      logic       a_mag;
      logic       a_min;
      logic       rgb_mag;
      logic       rgb_min;
      logic [2:0] scale;
      logic [5:0] bias;
      logic [7:0] clamp;
   } texu_detail_t;

   // Expanded 32-bit colour of one texel.
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } texu_argb_t;

endpackage

// *** rtl/texu_lod.sv ***
// Level-of-detail bias, clamp and minification decision.
`timescale 1ns/1ps
module texu_lod
   import texu_pkg::*;
(
   input  wire logic [7:0]          lod_i,
   input  wire texu_pkg::texu_level_t cfg_i,
   output logic     [5:0]          lod_o,
   output logic                    magnify_o
);
   import texu_pkg::*;

   logic signed [9:0] sum;   // Computed level plus signed bias.
   logic        [5:0] upper; // Lesser of 8.0 and the programmed maximum.
   logic        [5:0] clamped;

   // Bias, then clamp into the window; hitting the floor means magnification.
   always_comb begin
      sum       = $signed({2'b00, lod_i}) + 10'($signed(cfg_i.bias));
      upper     = (cfg_i.lod_max < TEXU_LOD_CEIL) ? cfg_i.lod_max : TEXU_LOD_CEIL;
      magnify_o = 1'b0;
      if (sum < $signed({4'h0, cfg_i.lod_min})) begin
         clamped   = cfg_i.lod_min;
         magnify_o = 1'b1;
      end else if (sum > $signed({4'h0, upper})) begin
         clamped = upper;
      end else begin
         clamped = sum[5:0];
      end
      // A forced zero fraction keeps only the whole level.
      lod_o = cfg_i.zero_frac ? {clamped[5:2], 2'b00} : clamped;
   end

endmodule

// *** rtl/texu_texel.sv ***
// Expansion of one 16-bit texel into 32-bit colour.
`timescale 1ns/1ps
module texu_texel
   import texu_pkg::*;
(
   input  wire logic [3:0]  format_i,
   input  wire logic [15:0] texel_i,
   input  wire logic [23:0] palette_i,
   input  wire logic [7:0]  luma_i,
   input  wire logic [26:0] chroma_i_i,
   input  wire logic [26:0] chroma_q_i,
   output texu_pkg::texu_argb_t color_o
);
   import texu_pkg::*;

   // Sum of luma and two signed chroma terms, saturated to a byte.
   function automatic logic [7:0] ncc_sum(input logic [7:0] y, input logic [8:0] i,
                                          input logic [8:0] q);
      logic signed [10:0] s;
      s = $signed({3'b000, y}) + 11'($signed(i)) + 11'($signed(q));
      if (s < 0) ncc_sum = 8'h00;
      else if (s > 11'sd255) ncc_sum = 8'hff;
      else ncc_sum = s[7:0];
   endfunction

   logic [15:0] t;
   assign t = texel_i;

   // Formats 7 and 15 are reserved and simply give zero.
   always_comb begin
      color_o = '0;
      unique case (format_i)
         TEXU_FMT_ARGB8332: color_o = {t[15:8], t[7:5], t[7:5], t[7:6],
                                       t[4:2], t[4:2], t[4:3], {4{t[1:0]}}};
         TEXU_FMT_ALCC: color_o = {t[15:8],
                                   ncc_sum(luma_i, chroma_i_i[26:18], chroma_q_i[26:18]),
                                   ncc_sum(luma_i, chroma_i_i[17:9], chroma_q_i[17:9]),
                                   ncc_sum(luma_i, chroma_i_i[8:0], chroma_q_i[8:0])};
         TEXU_FMT_RGB565: color_o = {8'hff, t[15:11], t[15:13],
                                     t[10:5], t[10:9], t[4:0], t[4:2]};
         TEXU_FMT_ARGB1555: color_o = {{8{t[15]}}, t[14:10], t[14:12],
                                       t[9:5], t[9:7], t[4:0], t[4:2]};
         TEXU_FMT_ARGB4444: color_o = {t[15:12], t[15:12], t[11:8], t[11:8],
                                       t[7:4], t[7:4], t[3:0], t[3:0]};
         TEXU_FMT_AI88: color_o = {t[15:8], t[7:0], t[7:0], t[7:0]};
         TEXU_FMT_AP88: color_o = {t[15:8], palette_i};
         default: color_o = '0;
      endcase
   end

endmodule

// *** rtl/texu_cfg.sv ***
// Texture unit configuration registers, tables, palette and lookup logic.
`timescale 1ns/1ps
// How it works
// - Format 10: opaque alpha, widen 565 channels
// - Format 13: alpha high byte, intensity to RGB
// - Format 14: alpha high byte, palette RGB
// - Add bias, clamp to min and min(8,max)
// - Floor clamp selects magnification filter
// - Split textures hold only odd or even levels
// - Aspect field gives power-of-two ratio, wider flag
// - Zero-fraction flag clears level fraction
// - Byte reverse, then swap halves of data
// - Hold detail clamp, bias and scale
// - Detail factor from bias, level, scale, clamp
// - Separate flag splits RGB and alpha filters
// - Base address is 19 bits, 8-byte units
// - Multi-base flag and level pick base
// - Two compression tables, switchable per triangle
// - Tables write-only: luma words, chroma words
// - Table 0 chroma with top bit writes palette
// - Palette index from data and address parity
// - Four palette lookups in one cycle
// - Mode bit chooses decompression table
// - Mode field gives texel format code
module texu_cfg
   import texu_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   // Wishbone slave.
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [31:0]            wb_dat_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic                   wb_we_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   output logic     [31:0]            wb_dat_o,
   output logic                       wb_ack_o,
   // Rendering side.
   input  wire logic [7:0]             lod_i,
   input  wire logic [3:0]             level_base_index_i,
   input  wire logic [3:0][15:0]       texel_i,
   input  wire logic [31:0]            tex_data_i,
   output logic     [5:0]             lod_o,
   output logic                       level_present_o,
   output logic                       rgb_bilinear_o,
   output logic                       alpha_bilinear_o,
   output logic     [1:0]             s_shrink_o,
   output logic     [1:0]             t_shrink_o,
   output logic     [18:0]            base_addr_o,
   output logic     [31:0]            tex_data_o,
   output logic     [7:0]             detail_factor_o,
   output logic                       direct_write_o,
   output texu_pkg::texu_argb_t [3:0] texel_o
);
   import texu_pkg::*;

   // Configuration registers.
   logic [31:0]  mode_q;           // Texture mode register.
   texu_level_t  level_q;          // Texture level control.
   texu_detail_t detail_q;         // Detail texture control.
   logic [3:0][18:0] base_q;       // Base addresses, level 0, 1, 2 and 3-up.

   // Table and palette storage; data only, so no reset is spent on it.
   logic [7:0]  luma_q   [0:31];   // Index {table, entry}.
   logic [26:0] chroma_q [0:15];   // Index {table, I0..I3 then Q0..Q3}.
   logic [23:0] pal_q    [0:255];  // Palette colours.

   // Bus decode.
   logic        ack_q;             // Acknowledge, one cycle per request.
   logic [31:0] rdata_q;           // Read data held for the answer.
   logic        req;               // A request is standing.
   logic        wr_go;             // Write takes effect at this edge.
   logic [5:0]  widx;              // Word index of the access.
   logic        full_word;         // All four byte lanes enabled.
   logic        tbl_hit;           // Access falls in one of the tables.
   logic        tbl_one;           // Table 1 rather than table 0.
   logic [3:0]  tbl_word;          // Word within the table.
   logic [31:0] lane_mask;         // Byte enables widened to bits.

   assign req       = wb_cyc_i & wb_stb_i;
   assign wr_go     = req & wb_we_i & ack_q;
   assign widx      = wb_adr_i[7:2];
   assign full_word = &wb_sel_i;
   assign tbl_one   = (widx[5:4] == TEXU_W_TABLE1[5:4]);
   assign tbl_word  = widx[3:0];
   assign tbl_hit   = ((widx[5:4] == TEXU_W_TABLE0[5:4]) | tbl_one) &&
                      (tbl_word < TEXU_TBL_WORDS);

   // Widen the select lines so partial writes touch only their lanes.
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         lane_mask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   // Merge new write data into an old word according to the lanes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   // Classic cycle: ack a cycle after the request, drop it the cycle after.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   // Read data is captured on the first request cycle; tables read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= TEXU_RESET_VAL;
      end else if (req & ~ack_q) begin
         unique case (widx)
            TEXU_W_MODE:   rdata_q <= mode_q;
            TEXU_W_LEVEL:  rdata_q <= {4'h0, level_q[27:0]};
            TEXU_W_DETAIL: rdata_q <= {10'h000, detail_q[21:0]};
            TEXU_W_BASE0, TEXU_W_BASE0 + 6'h1, TEXU_W_BASE0 + 6'h2, TEXU_W_BASE0 + 6'h3: begin
               rdata_q <= {13'h0000, base_q[2'(widx - TEXU_W_BASE0)]};
            end
            default:       rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // Mode register: format, table select and filter bits feed the datapath.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= TEXU_RESET_VAL;
      end else if (wr_go && widx == TEXU_W_MODE) begin
         mode_q <= merge(mode_q, wb_dat_i, lane_mask);
      end
   end

   // Level control register; reserved top bits are not stored.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_q <= texu_level_t'(TEXU_RESET_VAL);
      end else if (wr_go && widx == TEXU_W_LEVEL) begin
         level_q <= texu_level_t'(merge(level_q, wb_dat_i, lane_mask) & 32'h0fff_ffff);
      end
   end

   // Detail control register holds clamp, bias, scale and filter choices.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         detail_q <= texu_detail_t'(TEXU_RESET_VAL);
      end else if (wr_go && widx == TEXU_W_DETAIL) begin
         detail_q <= texu_detail_t'(merge(detail_q, wb_dat_i, lane_mask) & 32'h003f_ffff);
      end
   end

   // Four base address registers, one generate entry each.
   for (genvar n = 0; n < 4; n++) begin : g_base
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            base_q[n] <= TEXU_RESET_VAL[18:0];
         end else if (wr_go && widx == TEXU_W_BASE0 + 6'(n)) begin
            base_q[n] <= 19'(merge({13'h0000, base_q[n]}, wb_dat_i, lane_mask));
         end
      end
   end

   // Table writes need a full word; a partial lane write would tear entries.
   logic tbl_wr;     // Full-word write into a table.
   logic pal_wr;     // Table 0 chroma write redirected to the palette.
   logic luma_wr;    // Write of four luma entries.
   logic chroma_wr;  // Write of one chroma entry.

   always_comb begin
      tbl_wr    = wr_go & tbl_hit & full_word;
      luma_wr   = tbl_wr && (tbl_word < TEXU_TBL_LUMA);
      pal_wr    = tbl_wr && !tbl_one && (tbl_word >= TEXU_TBL_LUMA) &&
                  wb_dat_i[TEXU_PAL_MARK];
      chroma_wr = tbl_wr && (tbl_word >= TEXU_TBL_LUMA) && !pal_wr;
   end

   // Luma words pack four entries each, lowest entry in the low byte.
   always_ff @(posedge clk_i) begin
      if (luma_wr) begin
         for (int b = 0; b < 4; b++) begin
            luma_q[{tbl_one, tbl_word[1:0], 2'(b)}] <= wb_dat_i[b*8 +: 8];
         end
      end
   end

   // Chroma words hold three 9-bit signed values; upper bits are dropped.
   always_ff @(posedge clk_i) begin
      if (chroma_wr) begin
         chroma_q[{tbl_one, 3'(tbl_word - TEXU_TBL_LUMA)}] <= wb_dat_i[26:0];
      end
   end

   // Even and odd chroma addresses supply the low palette index bit.
   always_ff @(posedge clk_i) begin
      if (pal_wr) begin
         pal_q[{wb_dat_i[30:24], tbl_word[0]}] <= wb_dat_i[23:0];
      end
   end

   // Level of detail arithmetic sits in its own unit.
   logic [5:0] lod_c;    // Clamped level.
   logic       magnify;  // Level was held at its floor.

   texu_lod u_lod (
      .lod_i     (lod_i),
      .cfg_i     (level_q),
      .lod_o     (lod_c),
      .magnify_o (magnify)
   );

   // Filter choice per channel group; the filters are picked per pixel.
   logic rgb_bil;   // RGB bilinear.
   logic a_bil;     // Alpha bilinear.

   always_comb begin
      if (detail_q.separate) begin
         rgb_bil = magnify ? detail_q.rgb_mag : detail_q.rgb_min;
         a_bil   = magnify ? detail_q.a_mag : detail_q.a_min;
      end else begin
         rgb_bil = magnify ? mode_q[TEXU_MODE_MAG_FILT] : mode_q[TEXU_MODE_MIN_FILT];
         a_bil   = rgb_bil;
      end
   end

   // Detail factor: a negative difference gives zero, overflow saturates.
   logic signed [7:0]  det_diff;   // Bias minus whole level.
   logic        [14:0] det_shift;  // Shifted difference.
   logic        [7:0]  det_sat;    // Saturated to a byte.

   always_comb begin
      det_diff  = 8'($signed(detail_q.bias)) - $signed({2'b00, lod_c[5:0]} >> 2);
      det_shift = det_diff[7] ? 15'h0000 : 15'({det_diff[6:0]} << detail_q.scale);
      det_sat   = (det_shift > 15'h00ff) ? 8'hff : det_shift[7:0];
   end

   // Base select: a single base unless multi-base is on and the level is above 0.
   logic [18:0] base_sel;

   always_comb begin
      if (!level_q.multi_base || level_base_index_i == 4'h0) begin
         base_sel = base_q[0];
      end else if (level_base_index_i >= 4'h3) begin
         base_sel = base_q[3];
      end else begin
         base_sel = base_q[level_base_index_i[1:0]];
      end
   end

   // Endian fix: reverse bytes first, then swap the already reversed halves.
   logic [31:0] swz;

   always_comb begin
      swz = level_q.byte_reverse ? {tex_data_i[7:0], tex_data_i[15:8],
                                    tex_data_i[23:16], tex_data_i[31:24]} : tex_data_i;
      if (level_q.half_swap) begin
         swz = {swz[15:0], swz[31:16]};
      end
   end

   // Texel expansion; each texel has its own palette and table read port.
   logic [3:0] fmt;     // Format code for texel expansion.
   logic       tsel;    // Table used for decompression.
   texu_argb_t [3:0] texel_c;

   assign fmt  = mode_q[TEXU_MODE_FMT_LO +: 4];
   assign tsel = mode_q[TEXU_MODE_TBL_SEL];

   for (genvar k = 0; k < 4; k++) begin : g_texel
      texu_texel u_texel (
         .format_i   (fmt),
         .texel_i    (texel_i[k]),
         .palette_i  (pal_q[texel_i[k][7:0]]),
         .luma_i     (luma_q[{tsel, texel_i[k][7:4]}]),
         .chroma_i_i (chroma_q[{tsel, 1'b0, texel_i[k][3:2]}]),
         .chroma_q_i (chroma_q[{tsel, 1'b1, texel_i[k][1:0]}]),
         .color_o    (texel_c[k])
      );
   end

   // All rendering results leave through flip-flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lod_o            <= 6'h00;
         level_present_o  <= 1'b0;
         rgb_bilinear_o   <= 1'b0;
         alpha_bilinear_o <= 1'b0;
         base_addr_o      <= 19'h00000;
         tex_data_o       <= 32'h0000_0000;
         detail_factor_o  <= 8'h00;
         texel_o          <= '0;
      end else begin
         lod_o            <= lod_c;
         // A split texture only has levels of the chosen parity.
         level_present_o  <= !level_q.split || (lod_c[2] == level_q.odd);
         rgb_bilinear_o   <= rgb_bil;
         alpha_bilinear_o <= a_bil;
         base_addr_o      <= base_sel;
         tex_data_o       <= swz;
         // The larger of clamp and shifted difference, as the unit defines it.
         detail_factor_o  <= (det_sat > detail_q.clamp) ? det_sat : detail_q.clamp;
         texel_o          <= texel_c;
      end
   end

   // Aspect: the narrower side is 2^n smaller; square textures shrink neither.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_shrink_o <= 2'h0;
         t_shrink_o <= 2'h0;
      end else begin
         s_shrink_o <= level_q.horizontal_wider_flag ? 2'h0 : level_q.aspect;
         t_shrink_o <= level_q.horizontal_wider_flag ? level_q.aspect : 2'h0;
      end
   end

   // Direct writes are passed on; sequential download is the host's care.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         direct_write_o <= 1'b0;
      end else begin
         direct_write_o <= level_q.direct_write;
      end
   end

endmodule

// *** dv/texu_cfg_properties.sv ***
// Checker that watches the texture unit configuration block at its ports.
`timescale 1ns/1ps
module texu_chk
   import texu_pkg::*;
(
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic [7:0]           wb_adr_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic                 wb_we_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic [3:0][15:0]     texel_i,
   input wire logic [31:0]          tex_data_i,
   input wire logic [5:0]           lod_o,
   input wire logic                 level_present_o,
   input wire logic [1:0]           s_shrink_o,
   input wire logic [1:0]           t_shrink_o,
   input wire logic [18:0]          base_addr_o,
   input wire logic [31:0]          tex_data_o,
   input wire logic [7:0]           detail_factor_o,
   input wire texu_pkg::texu_argb_t [3:0] texel_o
);
   texu_level_t  lvl_q;  // Shadow of the level control register.
   texu_detail_t det_q;  // Shadow of the detail register.
   logic [31:0]  mode_q; // Shadow of the texture mode register.
   logic [18:0]  base_q; // Shadow of the first base address.
   // Shadows follow full-word writes only, so lane merging is not needed here.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_q <= '0;
         det_q <= '0;
         mode_q <= '0;
         base_q <= '0;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hf) begin
         case (wb_adr_i[7:2])
            TEXU_W_MODE:   mode_q <= wb_dat_i;
            TEXU_W_LEVEL:  lvl_q <= texu_level_t'(wb_dat_i);
            TEXU_W_DETAIL: det_q <= texu_detail_t'(wb_dat_i);
            TEXU_W_BASE0:  base_q <= wb_dat_i[18:0];
            default:       ;
         endcase
      end
   end
   // Expected colour of an opaque five-six-five texel.
   function automatic texu_argb_t e565(logic [15:0] t);
      return {8'hff, t[15:11], t[15:13], t[10:5], t[10:9], t[4:0], t[4:2]};
   endfunction
   // Byte reversal first, then the halves are exchanged.
   function automatic logic [31:0] swz(logic [31:0] d, logic rv, logic sw);
      logic [31:0] t;
      t = rv ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
      return sw ? {t[15:0], t[31:16]} : t;
   endfunction
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_high_read;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i[7:6] != 2'b00;
   endsequence
   sequence s_zero_ack;
      wb_ack_o && wb_dat_o == 32'h0 ##1 !wb_ack_o;
   endsequence
   AST_TABLE_READ_ZERO: assert property (s_high_read |=> s_zero_ack)
      else $error("high read did not answer zero");
   AST_OPAQUE_565: assert property (mode_q[11:8] == TEXU_FMT_RGB565 |=>
      texel_o[0] == e565($past(texel_i[0]))) else $error("bad 565 texel");
   AST_INTENSITY: assert property (mode_q[11:8] == TEXU_FMT_AI88 |=>
      texel_o[1] == {$past(texel_i[1][15:8]), {3{$past(texel_i[1][7:0])}}})
      else $error("bad intensity texel");
   AST_SWIZZLE: assert property (1'b1 |=> tex_data_o == swz($past(tex_data_i),
      $past(lvl_q.byte_reverse), $past(lvl_q.half_swap))) else $error("bad swizzle");
   AST_BASE_FIRST: assert property (!lvl_q.multi_base |=>
      base_addr_o == $past(base_q)) else $error("first base not used");
   AST_ALL_LEVELS: assert property (!lvl_q.split |=> level_present_o)
      else $error("level missing in unsplit texture");
   AST_SPLIT_PARITY: assert property (lvl_q.split |=>
      level_present_o == (lod_o[2] == $past(lvl_q.odd))) else $error("bad split parity");
   AST_SQUARE: assert property (lvl_q.aspect == 2'b00 |=>
      s_shrink_o == 2'b00 && t_shrink_o == 2'b00) else $error("square texture shrunk");
   AST_DETAIL_FLOOR: assert property (1'b1 |=>
      detail_factor_o >= $past(det_q.clamp)) else $error("detail factor below clamp");
endmodule
bind texu_cfg texu_chk u_chk (.*);

// *** dv/texture_unit_config_lookup_tb_top.sv ***
// Self-checking bench of the texture unit configuration and lookup block.
`timescale 1ns/1ps
module texture_unit_config_lookup_tb_top;
   import texu_pkg::*;
   logic             clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0;
   logic             wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, level_present_o;
   logic             rgb_bilinear_o, alpha_bilinear_o, direct_write_o;
   logic [7:0]       wb_adr_i = 8'h00, lod_i = 8'h00, detail_factor_o;
   logic [3:0]       wb_sel_i = 4'hf, level_base_index_i = 4'h0;
   logic [31:0]      wb_dat_i = 32'h0, tex_data_i = 32'h0, wb_dat_o, tex_data_o, rd;
   logic [31:0]      lfsr = 32'h9c0300a1;
   logic [3:0][15:0] texel_i = '0;
   logic [5:0]       lod_o;
   logic [1:0]       s_shrink_o, t_shrink_o;
   logic [18:0]      base_addr_o;
   texu_argb_t [3:0] texel_o;
   int               err_total = 0, checks_done = 0;
   texu_cfg u_dut (.*);
   initial forever #20 clk_i = ~clk_i;
   function automatic logic [31:0] nx(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Clamped level in the low bits, magnification flag on top.
   function automatic logic [6:0] elod(logic [7:0] l, texu_level_t c);
      int         s;
      logic [5:0] hi;
      s = int'(l) + int'($signed(c.bias));
      hi = (c.lod_max < TEXU_LOD_CEIL) ? c.lod_max : TEXU_LOD_CEIL;
      if (s < int'(c.lod_min))
         return {1'b1, c.lod_min};
      if (s > int'(hi))
         return {1'b0, hi};
      return {1'b0, 6'(s)};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle, bounded in case no acknowledge comes.
   task automatic bus(input logic we, input logic [5:0] w, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {w, 2'b00};
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
      if (n >= 20) begin
         err_total++;
         $display("mismatch at %0t: no acknowledge", $time);
         summarize();
      end
   endtask
   initial begin
      texu_level_t c;
      logic [6:0]  e;
      logic [31:0] b [4];
      logic [23:0] p [8];
      int          k;
      int          j;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      for (k = 0; k < 7; k++) begin
         bus(1'b0, 6'(k), 32'h0, 4'hf);
         chk(rd, TEXU_RESET_VAL);
      end
      foreach (b[k]) begin
         j = (k == 0) ? 6'h3f : (k == 1) ? TEXU_W_TABLE0 : TEXU_W_TABLE1;
         bus(1'b1, 6'(j), 32'hffff_ffff, 4'hf);
         bus(1'b0, 6'(j), 32'h0, 4'hf);
         chk(rd, 32'h0);
      end
      // A single lane must leave the other bytes alone.
      bus(1'b1, TEXU_W_DETAIL, 32'hffff_ffff, 4'h1);
      bus(1'b0, TEXU_W_DETAIL, 32'h0, 4'hf);
      chk(rd, 32'h0000_00ff);
      bus(1'b1, TEXU_W_DETAIL, lfsr & 32'h0001_ffff, 4'hf);
      bus(1'b0, TEXU_W_DETAIL, 32'h0, 4'hf);
      chk(rd, lfsr & 32'h0001_ffff);
      $display("test registers done");
      for (k = 0; k < 4; k++) begin
         lfsr = nx(lfsr);
         b[k] = lfsr;
         bus(1'b1, TEXU_W_BASE0 + 6'(k), lfsr, 4'hf);
         bus(1'b0, TEXU_W_BASE0 + 6'(k), 32'h0, 4'hf);
         chk(rd, {13'h0, lfsr[18:0]});
      end
      bus(1'b1, TEXU_W_LEVEL, 32'h0900_0000, 4'hf);
      for (k = 0; k < 6; k++) begin
         level_base_index_i <= 4'(k);
         repeat (2) @(posedge clk_i);
         chk(base_addr_o, b[k > 3 ? 3 : k][18:0]);
      end
      chk(direct_write_o, 1'b1);
      $display("test bases done");
      bus(1'b1, TEXU_W_MODE, 32'h0000_0e00, 4'hf);
      for (k = 0; k < 8; k++) begin
         lfsr = nx(lfsr);
         p[k] = lfsr[23:0];
         bus(1'b1, TEXU_W_TABLE0 + 6'(4 + k), {1'b1, 4'h5, 3'(k), p[k]}, 4'hf);
      end
      // Chroma writes must spare the palette.
      for (k = 0; k < 8; k++) begin
         bus(1'b1, TEXU_W_TABLE1 + 6'(4 + k), {1'b1, 4'h5, 3'(k), ~p[k]}, 4'hf);
         bus(1'b1, TEXU_W_TABLE0 + 6'(4 + k), {8'h00, ~p[k]}, 4'hf);
      end
      for (k = 0; k < 8; k += 4) begin
         for (j = 0; j < 4; j++)
            texel_i[j] <= {8'(j + 7), 4'h5, 3'(k + j), 1'(k + j)};
         repeat (2) @(posedge clk_i);
         for (j = 0; j < 4; j++)
            chk(texel_o[j], {8'(j + 7), p[k + j]});
      end
      $display("test palette done");
      bus(1'b1, TEXU_W_MODE, 32'h0000_0a02, 4'hf);
      for (k = 0; k < 40; k++) begin
         lfsr = nx(lfsr);
         c = texu_level_t'(lfsr & 32'h07ff_ffff);
         bus(1'b1, TEXU_W_LEVEL, 32'(c), 4'hf);
         lfsr = nx(lfsr);
         lod_i <= lfsr[7:0];
         tex_data_i <= lfsr;
         texel_i <= {lfsr, ~lfsr};
         e = elod(lfsr[7:0], c);
         repeat (2) @(posedge clk_i);
         chk(lod_o, c.zero_frac ? {e[5:2], 2'b00} : e[5:0]);
         chk(rgb_bilinear_o, !e[6]);
         chk(alpha_bilinear_o, (k > 20) ^ !e[6]);
         chk({s_shrink_o, t_shrink_o}, {c.aspect, 2'b00} >> 2 * c.horizontal_wider_flag);
         if (k == 20) begin
            bus(1'b1, TEXU_W_MODE, 32'h0000_0d06, 4'hf);
            bus(1'b1, TEXU_W_DETAIL, 32'h0032_0000, 4'hf);
         end
      end
      $display("test random done");
      summarize();
   end
endmodule
